//--- core/serial_bus_clock_config.v
// serial bus clock generation and configuration register
// assumes timer overflow strobes of one core clock, pins already split into in/oe,
// and a separate control block that sequences start, stop and acknowledge.
`timescale 1ns/100ps
`default_nettype none
`include "serial_bus_regs.vh"

module serial_bus_clock_config (
    input wire i_clock, // core clock, 10 MHz
    input wire i_nrst, // async reset, active low
    input wire [7:0] i_sfr_addr, // register address
    input wire i_sfr_wr, // register write strobe
    input wire [7:0] i_sfr_wdata, // register write data
    output reg [7:0] o_sfr_rdata, // register read data
    input wire [3:0] i_tmr_ovf, // overflow strobes: t0, t1, t2 high, t2 low
    input wire i_tmr3_split, // low timeout timer runs split
    output wire o_tmr3_reload_hi, // hold timer upper half in reload
    output wire o_tmr3_reload_lo, // hold timer lower half in reload
    input wire i_master_run, // control block wants master clocking
    input wire i_tx_valid, // next sda bit offered
    input wire i_tx_bit, // sda bit value, 1 releases
    output wire o_tx_ready, // bit buffer has room
    input wire i_scl, // scl pin level
    output wire o_scl_o, // scl output value, always 0
    output wire o_scl_oe, // scl pulled low while high
    input wire i_sda, // sda pin level
    output wire o_sda_o, // sda output value, always 0
    output wire o_sda_oe, // sda pulled low while high
    output wire o_scl_level, // synchronised scl
    output wire o_sda_level, // synchronised sda
    output reg o_bus_free, // one-cycle pulse on free timeout
    output wire o_start_seen, // one-cycle pulse on start
    output wire o_stop_seen, // one-cycle pulse on stop
    input wire i_slave_irq_req, // slave event from control block
    output wire o_slave_irq, // slave event passed on
    output wire o_slave_nack // nack all received addresses
);

localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_LOW = 3'b010;
localparam [2:0] S_HIGH = 3'b100;

////////////////////////////////////////////////////////////////////////
// configuration register

reg [7:0] cfg_q;
reg busy_q;
wire enable;
wire extend;
wire [1:0] cs_sel;

assign enable = cfg_q[`SBC_BIT_ENABLE];
assign extend = cfg_q[`SBC_BIT_EXTEND];
assign cs_sel = cfg_q[`SBC_CS_HI:`SBC_CS_LO];

always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        cfg_q <= `SBC_CFG_RESET;
    end else if (i_sfr_wr && i_sfr_addr == `SBC_CFG_ADDR) begin
        cfg_q <= i_sfr_wdata & ~(8'h01 << `SBC_BIT_BUSY);
    end
end

always @* begin
    o_sfr_rdata = 8'h00;
    if (i_sfr_addr == `SBC_CFG_ADDR) begin
        o_sfr_rdata = cfg_q;
        o_sfr_rdata[`SBC_BIT_BUSY] = busy_q;
    end
end

////////////////////////////////////////////////////////////////////////
// pin monitoring

wire [1:0] pins_s;
wire scl_s;
wire sda_s;
reg scl_d1_q;
reg sda_d1_q;

sync2 #(
    .WIDTH(2),
    .INIT(2'h3)
) u_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
);

assign scl_s = pins_s[1];
assign sda_s = pins_s[0];
assign o_scl_level = scl_s;
assign o_sda_level = sda_s;

always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        scl_d1_q <= 1'b1;
        sda_d1_q <= 1'b1;
    end else begin
        scl_d1_q <= scl_s;
        sda_d1_q <= sda_s;
    end
end

assign o_start_seen = enable && scl_s && scl_d1_q && sda_d1_q && !sda_s;
assign o_stop_seen = enable && scl_s && scl_d1_q && !sda_d1_q && sda_s;

////////////////////////////////////////////////////////////////////////
// clock source

function sel_tick;
    input [1:0] sel;
    input [3:0] ovf;
    begin
        case (sel)
            `SBC_CS_T0: sel_tick = ovf[0];
            `SBC_CS_T1: sel_tick = ovf[1];
            `SBC_CS_T2H: sel_tick = ovf[2];
            default: sel_tick = ovf[3];
        endcase
    end
endfunction

wire tick;
wire gen_tick;
wire free_tick;

assign tick = enable && sel_tick(cs_sel, i_tmr_ovf);
// source used only by master or free timeout
assign gen_tick = tick && i_master_run;
assign free_tick = tick && cfg_q[`SBC_BIT_FREE_TOE];

////////////////////////////////////////////////////////////////////////
// free timeout and busy

reg [3:0] free_cnt_q;

// more than ten periods with both lines high
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        free_cnt_q <= 4'h0;
        o_bus_free <= 1'b0;
    end else begin
        o_bus_free <= 1'b0;
        if (!scl_s || !sda_s || !cfg_q[`SBC_BIT_FREE_TOE] || !enable) begin
            free_cnt_q <= 4'h0;
        end else if (free_tick) begin
            if (free_cnt_q == `SBC_FREE_TICKS) begin
                o_bus_free <= busy_q;
                free_cnt_q <= 4'h0;
            end else begin
                free_cnt_q <= free_cnt_q + 4'h1;
            end
        end
    end
end

reg [2:0] st_q;

// busy set by start or own clocking, cleared by stop or free timeout
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        busy_q <= 1'b0;
    end else if (!enable) begin
        busy_q <= 1'b0;
    end else if (o_start_seen || st_q != S_IDLE) begin
        busy_q <= 1'b1;
    end else if (o_stop_seen || o_bus_free) begin
        busy_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// slave inhibit

reg inh_act_q;

// inhibit sampled at each start only
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        inh_act_q <= 1'b0;
    end else if (o_start_seen) begin
        inh_act_q <= cfg_q[`SBC_BIT_INHIBIT];
    end
end

// slave interrupts gated, master path untouched
assign o_slave_irq = enable && i_slave_irq_req && !inh_act_q;
assign o_slave_nack = inh_act_q;

////////////////////////////////////////////////////////////////////////
// low timeout timer control

assign o_tmr3_reload_hi = enable && cfg_q[`SBC_BIT_LOW_TOE] && scl_s;
// split timer keeps lower half counting
assign o_tmr3_reload_lo = o_tmr3_reload_hi && !i_tmr3_split;

////////////////////////////////////////////////////////////////////////
// master scl and sda generation

wire buf_valid;
wire buf_bit;
wire pop;
wire [3:0] hold_min;
wire [3:0] setup_min;
reg [1:0] hi_cnt_q;
reg [3:0] hold_cnt_q;
reg [3:0] setup_cnt_q;
reg bit_ok_q;
reg sda_q;
wire run;

assign run = enable && i_master_run;

// stalls here hold scl low, so the writer never loses a bit
bit_buffer #(
    .WIDTH(1)
) u_buf (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_bit),
    .o_in_ready(o_tx_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_bit),
    .i_out_ready(pop)
);

assign hold_min = extend ? `SBC_HOLD_EXT : `SBC_HOLD_STD;
assign setup_min = extend ? `SBC_SETUP_EXT : `SBC_SETUP_STD;

assign pop = (st_q == S_LOW) && (hold_cnt_q >= hold_min) && !bit_ok_q && buf_valid;

always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        st_q <= S_IDLE;
        hi_cnt_q <= 2'h0;
        hold_cnt_q <= 4'h0;
        setup_cnt_q <= 4'h0;
        bit_ok_q <= 1'b0;
        sda_q <= 1'b1;
    end else begin
        case (st_q)
            S_IDLE: begin
                sda_q <= 1'b1;
                // low phase begins on an overflow
                if (run && gen_tick) begin
                    st_q <= S_LOW;
                    hold_cnt_q <= 4'h0;
                    bit_ok_q <= 1'b0;
                end
            end
            S_LOW: begin
                if (!run) begin
                    st_q <= S_IDLE;
                end else begin
                    // low phase of whole overflow periods
                    // scl is only released on an overflow, so a phase that
                    // waited for data still ends on a period boundary
                    if (hold_cnt_q < hold_min) begin
                        hold_cnt_q <= hold_cnt_q + 4'h1;
                    end
                    // setup counts from the moment data arrives
                    if (pop) begin
                        sda_q <= buf_bit;
                        bit_ok_q <= 1'b1;
                        setup_cnt_q <= 4'h0;
                    end else if (bit_ok_q && setup_cnt_q < setup_min) begin
                        setup_cnt_q <= setup_cnt_q + 4'h1;
                    end
                    // at least one low period (more with extended timing) then two high periods
                    if (gen_tick && bit_ok_q && setup_cnt_q >= setup_min) begin
                        st_q <= S_HIGH;
                        hi_cnt_q <= 2'h0;
                    end
                end
            end
            S_HIGH: begin
                if (!run) begin
                    st_q <= S_IDLE;
                // stretched scl simply delays the high count
                end else if (scl_s && gen_tick) begin
                    if (hi_cnt_q == `SBC_HIGH_TICKS - 2'h1) begin
                        st_q <= S_LOW;
                        hold_cnt_q <= 4'h0;
                        bit_ok_q <= 1'b0;
                    end else begin
                        hi_cnt_q <= hi_cnt_q + 2'h1;
                    end
                end
            end
            default: begin
                st_q <= S_IDLE;
            end
        endcase
    end
end

assign o_scl_o = 1'b0;
assign o_sda_o = 1'b0;
assign o_scl_oe = (st_q == S_LOW);
assign o_sda_oe = (st_q != S_IDLE) && !sda_q;

endmodule // serial_bus_clock_config

`default_nettype wire

//--- core/serial_bus_regs.vh
// constants of the serial bus clock and configuration block
// included by the design files by bare name; definitions only
`ifndef SERIAL_BUS_REGS_VH
`define SERIAL_BUS_REGS_VH

// configuration register address on the special function bus
`define SBC_CFG_ADDR 8'hc1
`define SBC_CFG_RESET 8'h00

// field positions
`define SBC_BIT_ENABLE 7
`define SBC_BIT_INHIBIT 6
`define SBC_BIT_BUSY 5
`define SBC_BIT_EXTEND 4
`define SBC_BIT_LOW_TOE 3
`define SBC_BIT_FREE_TOE 2
`define SBC_CS_HI 1
`define SBC_CS_LO 0

// clock source codes
`define SBC_CS_T0 2'h0
`define SBC_CS_T1 2'h1
`define SBC_CS_T2H 2'h2
`define SBC_CS_T2L 2'h3

// sda timing in core clocks
`define SBC_SETUP_EXT 4'hb
`define SBC_HOLD_EXT 4'hc
`define SBC_SETUP_STD 4'h1
`define SBC_HOLD_STD 4'h3

// scl phases in clock source overflows
`define SBC_LOW_TICKS 2'h1
`define SBC_HIGH_TICKS 2'h2

// free bus after more than this many overflows
`define SBC_FREE_TICKS 4'ha

`endif

//--- core/sync2.v
// two flip-flop synchroniser for a group of pin levels
// assumes asynchronous inputs; output is safe to use on i_clock
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire i_clock, // core clock
    input wire i_nrst, // async reset, active low
    input wire [WIDTH-1:0] i_async, // pin levels
    output wire [WIDTH-1:0] o_sync // synchronised levels
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        meta_q <= INIT;
        sync_q <= INIT;
    end else begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end
end

assign o_sync = sync_q;

endmodule // sync2

`default_nettype wire

//--- core/bit_buffer.v
// two-entry buffer with valid/ready on both sides
// assumes one clock; push and pop may happen in the same cycle
`timescale 1ns/100ps
`default_nettype none

module bit_buffer #(
    parameter WIDTH = 1
) (
    input wire i_clock, // core clock
    input wire i_nrst, // async reset, active low
    input wire i_in_valid, // writer offers a word
    input wire [WIDTH-1:0] i_in_data, // word offered
    output wire o_in_ready, // buffer not full
    output wire o_out_valid, // buffer not empty
    output wire [WIDTH-1:0] o_out_data, // oldest word
    input wire i_out_ready // reader takes the word
);

reg [WIDTH-1:0] mem_q [0:1];
reg rd_q;
reg wr_q;
reg [1:0] cnt_q;
wire push;
wire pop;

assign o_in_ready = (cnt_q != 2'h2);
assign o_out_valid = (cnt_q != 2'h0);
assign o_out_data = mem_q[rd_q];
assign push = i_in_valid && o_in_ready;
assign pop = o_out_valid && i_out_ready;

always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        mem_q[0] <= {WIDTH{1'b0}};
        mem_q[1] <= {WIDTH{1'b0}};
        rd_q <= 1'b0;
        wr_q <= 1'b0;
        cnt_q <= 2'h0;
    end else begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
            wr_q <= ~wr_q;
        end
        if (pop) begin
            rd_q <= ~rd_q;
        end
        if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
end

endmodule // bit_buffer

`default_nettype wire

//--- verif/smbus_far_end.sv
// far side of the bus: pull-ups plus one device that may hold either line low
// assumes the bench commands every hold; released lines float high
`timescale 1ns/100ps
`default_nettype none

module smbus_far_end (
    input wire logic i_scl_oe, // controller pulls scl
    input wire logic i_sda_oe, // controller pulls sda
    input wire logic i_hold_scl, // far device stretches scl
    input wire logic i_hold_sda, // far device pulls sda
    output logic o_scl, // wired-and scl
    output logic o_sda // wired-and sda
);
    assign o_scl = !(i_scl_oe || i_hold_scl);
    assign o_sda = !(i_sda_oe || i_hold_sda);
endmodule // smbus_far_end

`default_nettype wire

//--- verif/serial_bus_clock_config_checker.sv
// concurrent checks on the serial bus clock and configuration block
// assumes a bind to the top module; sees its ports only
`timescale 1ns/100ps
`default_nettype none

module serial_bus_clock_config_checker (
    input wire logic i_clock, i_nrst, i_sfr_wr, i_tmr3_split, i_master_run, // inputs
    input wire logic i_tx_valid, i_tx_bit, i_scl, i_sda, i_slave_irq_req, // inputs
    input wire logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, // register bus
    input wire logic [3:0] i_tmr_ovf, // overflow strobes
    input wire logic o_tmr3_reload_hi, o_tmr3_reload_lo, o_tx_ready, o_scl_o, o_scl_oe, // outputs
    input wire logic o_sda_o, o_sda_oe, o_scl_level, o_sda_level, o_bus_free, // outputs
    input wire logic o_start_seen, o_stop_seen, o_slave_irq, o_slave_nack // outputs
);
    logic [7:0] cfg_q; // shadow of the configuration register
    logic sda_prev_q;
    logic [3:0] age_q; // cycles the sda drive has stood, saturating
    logic [3:0] ticks_q; // overflows seen with both lines high
    wire logic tick = i_tmr_ovf[cfg_q[1:0]];

    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_q <= 8'h00;
            sda_prev_q <= 1'b0;
            age_q <= 4'h0;
            ticks_q <= 4'h0;
        end else begin
            if (i_sfr_wr && i_sfr_addr == 8'hc1) begin
                cfg_q <= i_sfr_wdata & 8'hdf;
            end
            sda_prev_q <= o_sda_oe;
            age_q <= (o_sda_oe != sda_prev_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
            if (!(o_scl_level && o_sda_level && cfg_q[2])) begin
                ticks_q <= 4'h0;
            end else if (tick && ticks_q != 4'hf) begin
                ticks_q <= ticks_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    chk_reload_upper: assert property (o_tmr3_reload_hi == (cfg_q[7] && cfg_q[3] && o_scl_level))
        else $error("upper reload does not follow scl");
    chk_reload_lower: assert property (o_tmr3_reload_lo == (o_tmr3_reload_hi && !i_tmr3_split))
        else $error("lower reload wrong for split mode");
    chk_read_config: assert property (i_sfr_addr == 8'hc1 |-> (o_sfr_rdata & 8'hdf) == cfg_q)
        else $error("configuration read back wrong");
    chk_read_unmapped: assert property (i_sfr_addr != 8'hc1 |-> o_sfr_rdata == 8'h00)
        else $error("unmapped address reads nonzero");
    chk_slave_irq_gate: assert property (o_slave_irq == (cfg_q[7] && i_slave_irq_req && !o_slave_nack))
        else $error("slave event gating wrong");
    chk_nack_at_start: assert property (o_start_seen |=> o_slave_nack == $past(cfg_q[6]))
        else $error("inhibit not taken at start");
    chk_low_on_tick: assert property ($rose(o_scl_oe) |-> $past(tick))
        else $error("scl low not launched by selected overflow");
    chk_hold_std: assert property ($rose(o_scl_oe) && !cfg_q[4] |=> $stable(o_sda_oe) [*2])
        else $error("sda hold too short");
    chk_hold_ext: assert property ($rose(o_scl_oe) && cfg_q[4] |=> $stable(o_sda_oe) [*8])
        else $error("extended sda hold too short");
    chk_setup_ext: assert property ($fell(o_scl_oe) && cfg_q[4] && $past(i_master_run) |-> age_q >= 4'h9)
        else $error("extended sda setup too short");
    chk_free_after_ten: assert property (o_bus_free |-> ticks_q >= 4'ha)
        else $error("bus free too early");
    chk_busy_clears: assert property (o_bus_free && !o_start_seen |=> i_sfr_addr != 8'hc1 || !o_sfr_rdata[5])
        else $error("busy not cleared on free timeout");

    cover property (o_bus_free);
    cover property ($rose(o_scl_oe) && cfg_q[4]);
    cover property (o_start_seen && cfg_q[6]);
endmodule // serial_bus_clock_config_checker

`default_nettype wire

//--- verif/tb_serial_bus_clock_config.sv
// self-checking bench for the serial bus clock and configuration block
// assumes the far end model and the checker; inputs change 10 ns after a rise
`timescale 1ns/100ps
`default_nettype none

module tb_serial_bus_clock_config;
    logic i_clock, i_nrst, i_sfr_wr, i_tmr3_split, i_master_run, i_tx_valid, i_tx_bit;
    logic i_scl, i_sda, i_slave_irq_req, hold_scl, hold_sda, take;
    logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
    logic [3:0] i_tmr_ovf;
    logic o_tmr3_reload_hi, o_tmr3_reload_lo, o_tx_ready, o_scl_o, o_scl_oe, o_sda_o, o_sda_oe;
    logic o_scl_level, o_sda_level, o_bus_free, o_start_seen, o_stop_seen, o_slave_irq, o_slave_nack;
    logic [2:0] phase_q; // place within the 800 ns overflow period
    logic [2:0] idx; // next pattern bit offered
    logic exp_q[$]; // bits taken, in order
    int n_errors, n_compared, n_rise, hi_len, lo_len, k, j;
    realtime t_rise, t_fall;

    serial_bus_clock_config dut (.*);
    smbus_far_end far (.i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .i_hold_scl(hold_scl),
        .i_hold_sda(hold_sda), .o_scl(i_scl), .o_sda(i_sda));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        cyc(1);
        i_sfr_wr = 1'b0;
        i_sfr_addr = 8'hc1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        i_sfr_addr = a;
        #1 check(name, o_sfr_rdata, exp);
        i_sfr_addr = 8'hc1;
    endtask

    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // overflow strobes of all four sources, each once per 800 ns, and the bit feeder
    always @(posedge i_clock) begin
        take = i_tx_valid && o_tx_ready;
        #10;
        i_tmr_ovf = 4'h0;
        if (phase_q < 3'h4) i_tmr_ovf[phase_q[1:0]] = 1'b1;
        phase_q = phase_q + 3'h1;
        if (take) exp_q.push_back(i_tx_bit);
        if (take) idx = idx + 3'h1;
        i_tx_bit = 8'hb2 >> (3'h7 - idx);
    end

    always @(posedge i_scl) begin
        t_rise = $realtime;
        lo_len = (t_rise - t_fall) / 100;
        if (i_master_run && exp_q.size() > 0) check("sda at rise", {7'h0, i_sda}, {7'h0, exp_q.pop_front()});
        n_rise++;
    end

    always @(negedge i_scl) begin
        t_fall = $realtime;
        hi_len = (t_fall - t_rise) / 100;
    end

    initial begin
        #1_000_000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        {i_nrst, i_sfr_wr, i_tmr3_split, i_master_run, i_tx_valid, i_tx_bit} = 6'h0;
        {i_slave_irq_req, hold_scl, hold_sda, phase_q, idx, i_tmr_ovf} = 13'h0;
        {i_sfr_addr, i_sfr_wdata, n_errors, n_compared, n_rise} = '0;
        t_rise = 0.0;
        t_fall = 0.0;
        i_sfr_addr = 8'hc1;
        cyc(10);
        i_nrst = 1'b1;
        rd(8'hc1, 8'h00, "reset value");
        wr(8'hc1, 8'h7f);
        rd(8'hc1, 8'h5f, "read back");
        wr(8'h40, 8'h00);
        rd(8'h40, 8'h00, "unmapped");
        rd(8'hc1, 8'h5f, "no alias");
        check("reload while disabled", o_tmr3_reload_hi, 8'h0);
        wr(8'hc1, 8'h88);
        check("reload scl high", o_tmr3_reload_hi, 8'h1);
        i_tmr3_split = 1'b1;
        #1 check("split lower half", o_tmr3_reload_lo, 8'h0);
        hold_scl = 1'b1;
        cyc(4);
        check("count scl low", o_tmr3_reload_hi, 8'h0);
        wr(8'hc1, 8'h08); // timeout handler disables
        check("reload off when disabled", o_tmr3_reload_hi, 8'h0);
        wr(8'hc1, 8'h88); // and re-enables
        hold_scl = 1'b0;
        i_tmr3_split = 1'b0;
        // every clock source launches the low phase one cycle after its strobe
        for (k = 0; k < 4; k++) begin
            wr(8'hc1, 8'h80 | k[7:0]);
            i_master_run = 1'b1;
            i_tx_valid = 1'b1;
            for (j = 0; j < 40 && !o_scl_oe; j++) cyc(1);
            #1 check("source phase", {5'h0, phase_q - 3'h2}, k[7:0]);
            for (j = 0; j < 200 && (o_scl_oe || o_sda_oe); j++) cyc(1);
            i_master_run = 1'b0;
            cyc(3);
        end
        // extended timing with free timeout armed, then a stretch by the far device
        wr(8'hc1, 8'h94);
        i_master_run = 1'b1;
        n_rise = 0;
        for (j = 0; j < 400 && n_rise < 4; j++) cyc(1);
        check("high phase", {7'h0, hi_len >= 16}, 8'h1);
        check("low phase", {7'h0, lo_len >= 8}, 8'h1);
        check("bit period", {7'h0, hi_len + lo_len >= 24}, 8'h1);
        rd(8'hc1, 8'hb4, "busy as master");
        for (j = 0; j < 40 && !o_scl_oe; j++) cyc(1);
        hold_scl = 1'b1;
        cyc(40);
        hold_scl = 1'b0;
        n_rise = 0;
        for (j = 0; j < 200 && n_rise < 3; j++) cyc(1);
        check("resumes after stretch", {7'h0, hi_len >= 16}, 8'h1);
        for (j = 0; j < 200 && (o_scl_oe || o_sda_oe); j++) cyc(1);
        i_master_run = 1'b0;
        i_tx_valid = 1'b0;
        cyc(120);
        rd(8'hc1, 8'h94, "busy after free");
        // slave inhibit takes hold at a start and lasts until the next one
        wr(8'hc1, 8'hc0);
        i_slave_irq_req = 1'b1;
        hold_sda = 1'b1;
        cyc(4);
        check("nack after start", o_slave_nack, 8'h1);
        rd(8'hc1, 8'he0, "busy after start");
        check("sda seen low", {7'h0, o_sda_level}, 8'h0);
        check("open drain values", {6'h0, o_scl_o, o_sda_o}, 8'h00);
        check("slave event blocked", o_slave_irq, 8'h0);
        wr(8'hc1, 8'h80);
        check("inhibit kept", o_slave_irq, 8'h0);
        hold_sda = 1'b0;
        cyc(4);
        hold_sda = 1'b1;
        cyc(4);
        check("nack released", o_slave_nack, 8'h0);
        check("slave event passed", o_slave_irq, 8'h1);
        wr(8'hc1, 8'h00);
        check("disabled interface", o_slave_irq, 8'h0);
        hold_sda = 1'b0;
        cyc(4);
        report_and_stop();
    end
endmodule // tb_serial_bus_clock_config

bind serial_bus_clock_config serial_bus_clock_config_checker chk (.*);

`default_nettype wire
